// ==== include/sber_pkg.sv ====
// Purpose: Shared constants and carriers for the status byte and standard event register set.
// Assumes: Commands arrive already parsed, one per cycle, from the command interpreter.
// Notes: All masks and bit positions used by more than one file live here.
package sber_pkg;
  localparam int unsigned SBER_W        = 8;
  localparam int unsigned SB_ERRQ_BIT   = 2;
  localparam int unsigned SB_QUES_BIT   = 3;
  localparam int unsigned SB_MAV_BIT    = 4;
  localparam int unsigned SB_ESB_BIT    = 5;
  localparam int unsigned SB_MSS_BIT    = 6;
  localparam int unsigned SE_OPC_BIT    = 0;
  localparam logic [7:0]  SE_USED_MASK  = 8'hBD;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  EVENT_RESET   = 8'h00;
  localparam logic [7:0]  OPC_RESPONSE  = 8'h01;
  localparam int unsigned OPER_EV_W     = 16;

  typedef enum logic [3:0] {
    SBER_CMD_NONE,
    SBER_CMD_SRE_WR,
    SBER_CMD_SRE_RD,
    SBER_CMD_STB_RD,
    SBER_CMD_ESE_WR,
    SBER_CMD_ESE_RD,
    SBER_CMD_ESR_RD,
    SBER_CMD_CLS,
    SBER_CMD_OPC,
    SBER_CMD_OPC_RD
  } sber_cmd_t;

  typedef struct packed {
    sber_cmd_t  cmd;
    logic [7:0] value;
  } sber_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } sber_resp_t;
endpackage : sber_pkg

// ==== rtl/sber_evt_latch.sv ====
// Purpose: One latched event register with enable mask and summary output.
// Assumes: Set and clear are single-cycle pulses in the clock domain.
// Notes: A set arriving with a clear survives so no event is lost.
`timescale 1ns/10ps
`default_nettype none
module sber_evt_latch #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] enable_i,
  output logic      [W-1:0] event_o,
  output logic              summary_o
);
  logic [W-1:0] event_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      event_reg <= '0;
    end else if (clr_i) begin
      event_reg <= set_i;
    end else begin
      event_reg <= event_reg | set_i;
    end
  end

  assign event_o   = event_reg;
  assign summary_o = |(event_reg & enable_i);
endmodule : sber_evt_latch
`default_nettype wire

// ==== rtl/sber_status_regs.sv ====
// Purpose: Status byte, service request enable, standard event and its enable mask.
// Assumes: The parser delivers one decoded common command per valid cycle with its value.
// Notes: Register reads answer one cycle after the command as a registered value with a valid pulse; SBER_CMD_OPC_RD answers later on opc_resp_o.
`timescale 1ns/10ps
`default_nettype none
module sber_status_regs
  import sber_pkg::*;
#(
  parameter int unsigned OEV_W = OPER_EV_W
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             req_valid_i,
  input  wire sber_req_t        req_i,
  input  wire logic             ops_pending_i,
  input  wire logic [7:0]       std_event_set_i,
  input  wire logic             error_queue_nonempty_i,
  input  wire logic             message_available_i,
  input  wire logic [OEV_W-1:0] oper_event_set_i,
  input  wire logic [OEV_W-1:0] meas_event_set_i,
  input  wire logic [OEV_W-1:0] ques_event_set_i,
  input  wire logic [OEV_W-1:0] ques_enable_i,
  output sber_resp_t            resp_o,
  output logic                  opc_resp_valid_o,
  output logic [7:0]            opc_resp_o,
  output logic [7:0]            status_byte_o,
  output logic                  service_request_o,
  output logic [OEV_W-1:0]      oper_event_o,
  output logic [OEV_W-1:0]      meas_event_o,
  output logic [OEV_W-1:0]      ques_event_o
);
  typedef enum logic [1:0] {
    SBER_OPC_IDLE,
    SBER_OPC_WAIT_FLAG,
    SBER_OPC_WAIT_QUERY
  } sber_opc_state_t;

  logic [7:0]      service_request_enable_mask_reg;
  logic [7:0]      std_event_enable_mask_reg;
  logic [7:0]      std_event_latch;
  logic            std_summary;
  logic            ques_summary;
  logic [7:0]      std_set;
  logic            opc_fire;
  logic            cls_hit;
  logic            esr_hit;
  logic [7:0]      status_low;
  logic            master_summary_flag;
  sber_opc_state_t opc_state_reg;
  sber_opc_state_t opc_state_next;
  sber_resp_t      resp_reg;
  logic            opc_resp_valid_reg;

  assign cls_hit = req_valid_i && (req_i.cmd == SBER_CMD_CLS);
  assign esr_hit = req_valid_i && (req_i.cmd == SBER_CMD_ESR_RD);

  // Masks are untouched by clear-status; only reset and their own write commands change them.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      service_request_enable_mask_reg <= MASK_RESET;
    end else if (req_valid_i && req_i.cmd == SBER_CMD_SRE_WR) begin
      service_request_enable_mask_reg <= req_i.value;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      std_event_enable_mask_reg <= MASK_RESET;
    end else if (req_valid_i && req_i.cmd == SBER_CMD_ESE_WR) begin
      std_event_enable_mask_reg <= req_i.value;
    end
  end

  always_comb begin
    opc_state_next = opc_state_reg;
    opc_fire       = 1'b0;
    unique case (opc_state_reg)
      SBER_OPC_IDLE: begin
        if (req_valid_i && req_i.cmd == SBER_CMD_OPC) begin
          opc_state_next = SBER_OPC_WAIT_FLAG;
        end else if (req_valid_i && req_i.cmd == SBER_CMD_OPC_RD) begin
          opc_state_next = SBER_OPC_WAIT_QUERY;
        end
      end
      SBER_OPC_WAIT_FLAG: begin
        if (!ops_pending_i) begin
          opc_fire       = 1'b1;
          opc_state_next = SBER_OPC_IDLE;
        end
      end
      SBER_OPC_WAIT_QUERY: begin
        if (!ops_pending_i) begin
          opc_state_next = SBER_OPC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      opc_state_reg <= SBER_OPC_IDLE;
    end else begin
      opc_state_reg <= opc_state_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      opc_resp_valid_reg <= 1'b0;
    end else begin
      opc_resp_valid_reg <= (opc_state_reg == SBER_OPC_WAIT_QUERY) && !ops_pending_i;
    end
  end

  assign opc_resp_valid_o = opc_resp_valid_reg;
  assign opc_resp_o       = opc_resp_valid_reg ? OPC_RESPONSE : 8'h00;

  // Unused event positions are forced low so they always read as zero.
  always_comb begin
    std_set             = std_event_set_i & SE_USED_MASK;
    std_set[SE_OPC_BIT] = std_event_set_i[SE_OPC_BIT] | opc_fire;
  end

  sber_evt_latch #(
    .W (8)
  ) u_std_event (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .set_i     (std_set),
    .clr_i     (cls_hit | esr_hit),
    .enable_i  (std_event_enable_mask_reg),
    .event_o   (std_event_latch),
    .summary_o (std_summary)
  );

  sber_evt_latch #(
    .W (OEV_W)
  ) u_oper_event (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .set_i     (oper_event_set_i),
    .clr_i     (cls_hit),
    .enable_i  ({OEV_W{1'b0}}),
    .event_o   (oper_event_o),
    .summary_o ()
  );

  sber_evt_latch #(
    .W (OEV_W)
  ) u_meas_event (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .set_i     (meas_event_set_i),
    .clr_i     (cls_hit),
    .enable_i  ({OEV_W{1'b0}}),
    .event_o   (meas_event_o),
    .summary_o ()
  );

  sber_evt_latch #(
    .W (OEV_W)
  ) u_ques_event (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .set_i     (ques_event_set_i),
    .clr_i     (cls_hit),
    .enable_i  (ques_enable_i),
    .event_o   (ques_event_o),
    .summary_o (ques_summary)
  );

  // ESB and QUES summary bits follow the event latches, so clear-status empties them; error-queue and MAV bits follow their inputs.
  always_comb begin
    status_low              = 8'h00;
    status_low[SB_ERRQ_BIT] = error_queue_nonempty_i;
    status_low[SB_QUES_BIT] = ques_summary;
    status_low[SB_MAV_BIT]  = message_available_i;
    status_low[SB_ESB_BIT]  = std_summary;
  end

  assign master_summary_flag = |(status_low & service_request_enable_mask_reg);

  always_comb begin
    status_byte_o             = status_low;
    status_byte_o[SB_MSS_BIT] = master_summary_flag;
  end

  assign service_request_o = master_summary_flag;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      resp_reg <= '0;
    end else begin
      resp_reg.valid <= 1'b0;
      if (req_valid_i) begin
        unique case (req_i.cmd)
          SBER_CMD_SRE_RD: begin
            resp_reg.valid <= 1'b1;
            resp_reg.value <= service_request_enable_mask_reg;
          end
          SBER_CMD_STB_RD: begin
            resp_reg.valid <= 1'b1;
            resp_reg.value <= status_byte_o;
          end
          SBER_CMD_ESE_RD: begin
            resp_reg.valid <= 1'b1;
            resp_reg.value <= std_event_enable_mask_reg;
          end
          SBER_CMD_ESR_RD: begin
            resp_reg.valid <= 1'b1;
            resp_reg.value <= std_event_latch;
          end
          default: begin
            resp_reg.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  assign resp_o = resp_reg;
endmodule : sber_status_regs
`default_nettype wire

// ==== dv/sber_chk.sv ====
// Purpose: Port-level checks for the status byte and event register set.
// Assumes: One command per cycle; register reads answer one cycle later, SBER_CMD_OPC_RD two cycles later at the earliest.
// Notes: Mask copies are rebuilt here from the command stream.
`timescale 1ns/10ps
`default_nettype none
module sber_chk
  import sber_pkg::*;
#(
  parameter int unsigned OEV_W = OPER_EV_W
) (
  input wire logic             clock_i,
  input wire logic             rst_i,
  input wire logic             req_valid_i,
  input wire sber_req_t        req_i,
  input wire logic             ops_pending_i,
  input wire logic [7:0]       std_event_set_i,
  input wire logic [OEV_W-1:0] oper_event_set_i,
  input wire logic [OEV_W-1:0] meas_event_set_i,
  input wire logic [OEV_W-1:0] ques_event_set_i,
  input wire sber_resp_t       resp_o,
  input wire logic             opc_resp_valid_o,
  input wire logic [7:0]       opc_resp_o,
  input wire logic [7:0]       status_byte_o,
  input wire logic [OEV_W-1:0] oper_event_o,
  input wire logic [OEV_W-1:0] meas_event_o,
  input wire logic [OEV_W-1:0] ques_event_o
);
  logic [7:0] sre_reg;
  logic [7:0] ese_reg;
  wire logic go = req_valid_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sre_reg <= 8'h00;
      ese_reg <= 8'h00;
    end else if (go && req_i.cmd == SBER_CMD_SRE_WR) sre_reg <= req_i.value;
    else if (go && req_i.cmd == SBER_CMD_ESE_WR) ese_reg <= req_i.value;
  end
  property p_sre_rd; go && req_i.cmd == SBER_CMD_SRE_RD |=> resp_o == {1'b1, sre_reg}; endproperty
  a_sre_rd: assert property (p_sre_rd) else $error("mask read wrong");
  property p_ese_rd; go && req_i.cmd == SBER_CMD_ESE_RD |=> resp_o == {1'b1, ese_reg}; endproperty
  a_ese_rd: assert property (p_ese_rd) else $error("enable read wrong");
  property p_stb_rd;
    go && req_i.cmd == SBER_CMD_STB_RD |=> resp_o == {1'b1, $past(status_byte_o)};
  endproperty
  a_stb_rd: assert property (p_stb_rd) else $error("status read wrong");
  property p_mss;
    status_byte_o[6] == |({status_byte_o[7], status_byte_o[5:0]} & {sre_reg[7], sre_reg[5:0]});
  endproperty
  a_mss: assert property (p_mss) else $error("summary bit wrong");
  property p_unused; status_byte_o[1:0] == 2'b00 && !status_byte_o[7]; endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_opc_q; opc_resp_valid_o |-> opc_resp_o == 8'h01 && !$past(ops_pending_i); endproperty
  a_opc_q: assert property (p_opc_q) else $error("early reply");
  property p_opc_go;
    go && req_i.cmd == SBER_CMD_OPC_RD && !ops_pending_i ##1 !ops_pending_i |=> opc_resp_valid_o;
  endproperty
  a_opc_go: assert property (p_opc_go) else $error("reply missing");
  property p_cls;
    go && req_i.cmd == SBER_CMD_CLS && std_event_set_i == 8'h00 && (oper_event_set_i |
      meas_event_set_i | ques_event_set_i) == '0 |=> (oper_event_o | meas_event_o |
      ques_event_o) == '0 && status_byte_o[5] == 1'b0 && status_byte_o[3] == 1'b0;
  endproperty
  a_cls: assert property (p_cls) else $error("clear left bits");
endmodule : sber_chk
bind sber_status_regs sber_chk #(.OEV_W(OEV_W)) u_chk (.*);
`default_nettype wire

// ==== dv/sber_host.sv ====
// Purpose: Remote host issuing one decoded command at a time.
// Assumes: Commands launch at the falling edge and last one cycle.
// Notes: A released value shows its inverse, never the old data.
`timescale 1ns/10ps
`default_nettype none
module sber_host
  import sber_pkg::*;
(
  input  wire logic clock_i,
  output logic      req_valid_o,
  output sber_req_t req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '{SBER_CMD_NONE, 8'h00};
  end
  task automatic send(input sber_cmd_t c, input logic [7:0] v);
    @(negedge clock_i);
    req_valid_o = 1'b1;
    req_o = '{c, v};
    @(negedge clock_i);
    req_valid_o = 1'b0;
    req_o = '{SBER_CMD_NONE, ~v};
  endtask : send
endmodule : sber_host
`default_nettype wire

// ==== dv/status_byte_event_regs_test.sv ====
// Purpose: Self-checking bench for the status register set.
// Assumes: Responses are sampled at the falling edge after the command.
// Notes: Table rows cover masks; events, clear and completion follow.
`timescale 1ns/10ps
`default_nettype none
module status_byte_event_regs_test
  import sber_pkg::*;
;
  typedef struct packed {
    sber_cmd_t  cmd;
    logic [7:0] value;
    logic [7:0] exp_v;
  } sber_row_t;
  localparam sber_row_t ROWS [8] = '{'{SBER_CMD_SRE_WR, 8'h07, 8'h00},
    '{SBER_CMD_SRE_RD, 8'h00, 8'h07}, '{SBER_CMD_SRE_WR, 8'hFF, 8'h00},
    '{SBER_CMD_ESE_WR, 8'h41, 8'h00}, '{SBER_CMD_SRE_RD, 8'h00, 8'hFF},
    '{SBER_CMD_ESE_RD, 8'h00, 8'h41}, '{SBER_CMD_ESE_WR, 8'h00, 8'h00},
    '{SBER_CMD_ESE_RD, 8'h00, 8'h00}};
  logic clock_i = 1'b0, rst_i = 1'b1, ops_pending_i = 1'b0;
  logic error_queue_nonempty_i = 1'b0, message_available_i = 1'b0, req_valid_i;
  logic [7:0] std_event_set_i = 8'h00, opc_resp_o, status_byte_o;
  logic [15:0] oper_event_set_i = 16'h0000, meas_event_set_i = 16'h0000;
  logic [15:0] ques_event_set_i = 16'h0000, ques_enable_i = 16'hFFFF;
  logic [15:0] oper_event_o, meas_event_o, ques_event_o;
  logic opc_resp_valid_o, service_request_o;
  sber_req_t req_i;
  sber_resp_t resp_o;
  int errors = 0, tests_run = 0, n;
  always #4 clock_i = ~clock_i;
  sber_host H (.clock_i(clock_i), .req_valid_o(req_valid_i), .req_o(req_i));
  sber_status_regs DUT (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #40000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    foreach (ROWS[i]) begin
      H.send(ROWS[i].cmd, ROWS[i].value);
      if (ROWS[i].cmd inside {SBER_CMD_SRE_RD, SBER_CMD_ESE_RD})
        chk(resp_o, {1'b1, ROWS[i].exp_v});
    end
    H.send(SBER_CMD_ESE_WR, 8'h02);
    H.send(SBER_CMD_SRE_WR, 8'h20);
    std_event_set_i = 8'hFF;
    @(negedge clock_i) std_event_set_i = 8'h00;
    chk(status_byte_o, 8'h00);
    H.send(SBER_CMD_ESE_WR, 8'h01);
    chk(status_byte_o, 8'h60);
    repeat (2) begin
      H.send(SBER_CMD_STB_RD, 8'h00);
      chk(resp_o, 9'h160);
    end
    H.send(SBER_CMD_ESR_RD, 8'h00);
    chk(resp_o, 9'h1BD);
    H.send(SBER_CMD_ESR_RD, 8'h00);
    chk(resp_o, 9'h100);
    {error_queue_nonempty_i, message_available_i, std_event_set_i} = 10'h301;
    {oper_event_set_i, meas_event_set_i, ques_event_set_i} = {3{16'h8001}};
    @(negedge clock_i) {std_event_set_i, oper_event_set_i, meas_event_set_i} = '0;
    ques_event_set_i = 16'h0000;
    chk(status_byte_o, 8'h7C);
    chk(service_request_o, 1'b1);
    chk(oper_event_o, 16'h8001);
    chk(meas_event_o, 16'h8001);
    chk(ques_event_o, 16'h8001);
    // The status byte is combinational, so let an edge pass before looking again.
    {error_queue_nonempty_i, message_available_i} = 2'b00;
    @(negedge clock_i);
    chk(status_byte_o, 8'h68);
    H.send(SBER_CMD_CLS, 8'h00);
    chk(status_byte_o | oper_event_o | meas_event_o | ques_event_o, 16'h0000);
    chk(service_request_o, 1'b0);
    H.send(SBER_CMD_SRE_RD, 8'h00);
    chk(resp_o, 9'h120);
    H.send(SBER_CMD_ESE_RD, 8'h00);
    chk(resp_o, 9'h101);
    ops_pending_i = 1'b1;
    H.send(SBER_CMD_OPC, 8'h00);
    repeat (4) @(negedge clock_i);
    chk(status_byte_o[5], 1'b0);
    ops_pending_i = 1'b0;
    repeat (2) @(negedge clock_i);
    H.send(SBER_CMD_ESR_RD, 8'h00);
    chk(resp_o, 9'h101);
    for (int p = 1; p >= 0; p--) begin
      ops_pending_i = p[0];
      H.send(SBER_CMD_OPC_RD, 8'h00);
      // The reply is a one-cycle pulse, so look at the first cycle it can stand.
      @(negedge clock_i);
      chk(opc_resp_valid_o, p == 0);
      ops_pending_i = 1'b0;
      for (n = 0; !opc_resp_valid_o && n < 4; n++) @(negedge clock_i);
      chk({opc_resp_valid_o, opc_resp_o}, 9'h101);
      @(negedge clock_i);
    end
    rst_i = 1'b1;
    @(negedge clock_i) rst_i = 1'b0;
    H.send(SBER_CMD_SRE_RD, 8'h00);
    chk(resp_o, 9'h100);
    print_verdict();
  end
endmodule : status_byte_event_regs_test
`default_nettype wire
